// ===== rtl/memory_space_decoder.sv
// memory_space_decoder: routes cpu code and data accesses to targets
// assumes a single cpu request per cycle held until the cycle it is taken
`timescale 1ns/1ps
module memory_space_decoder (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_n,
	// cpu request
	input  wire logic        req,
	input  wire logic        fetch,
	input  wire logic        write,
	input  wire logic        word,
	input  wire logic        bit_op,
	input  wire logic        gpr_op,
	input  wire logic [3:0]  gpr_idx,
	input  wire logic        stack_op,
	input  wire logic [23:0] addr,
	input  wire logic [15:0] wdata,
	// protection and mode settings
	input  wire logic        ext_bus_present,
	input  wire logic [15:0] bank_base_pointer,
	input  wire logic [15:0] stack_overflow_limit,
	input  wire logic [15:0] stack_underflow_limit,
	input  wire logic [15:0] sector_wprot,
	input  wire logic        flash_rprot,
	input  wire logic [15:0] password,
	input  wire logic        pw_strobe,
	input  wire logic        pw_relock,
	input  wire logic [14:0] pram_prot_size,
	input  wire logic        pram_prot_en,
	input  wire logic        parity_en,
	input  wire logic        ecc_en,
	// target side
	input  wire logic [15:0] tgt_rdata,
	input  wire logic [4:0]  tgt_check,
	input  wire logic        tgt_parity,
	input  wire logic        tgt_done,
	output logic             tgt_req,
	output logic [3:0]       tgt_sel,
	output logic [23:0]      tgt_addr,
	output logic [1:0]       tgt_be,
	output logic             tgt_write,
	output logic [15:0]      tgt_wdata,
	output logic             tgt_bit_ok,
	output logic [7:0]       tgt_segment,
	output logic [1:0]       tgt_page,
	output logic [6:0]       tgt_flash_block,
	// cpu answer
	output logic             ack,
	output logic [15:0]      rdata,
	output logic             err_parity,
	output logic             err_align,
	output logic             err_prot,
	output logic             stack_overflow,
	output logic             stack_underflow,
	output logic             strict_order,
	output logic             flash_unlocked
);
	memory_space_decoder_pkg::target_t tgt_c;
	memory_space_decoder_pkg::target_t tgt_d, tgt_q;
	memory_space_decoder_pkg::unlock_t unlk_d, unlk_q;
	logic [23:0] ea;
	logic [1:0]  be_c;
	logic        bit_ok_c;
	logic        wp_c;
	logic        rp_c;
	logic        misal_c;
	logic        block_c;
	logic        ovf_c;
	logic        unf_c;
	logic        busy_d, busy_q;
	logic        ext_d, ext_q;
	logic        req_d, req_q;
	logic [3:0]  sel_d, sel_q;
	logic [23:0] taddr_d, taddr_q;
	logic [1:0]  be_d, be_q;
	logic        wr_d, wr_q;
	logic [15:0] wd_d, wd_q;
	logic        bok_d, bok_q;
	logic        ack_d, ack_q;
	logic [15:0] rd_d, rd_q;
	logic        perr_d, perr_q;
	logic        aerr_d, aerr_q;
	logic        perr2_d, perr2_q;
	logic        ovf_d, ovf_q;
	logic        unf_d, unf_q;
	logic        strict_d, strict_q;
	logic        byte_hi_d, byte_hi_q;
	logic        word_d, word_q;
	logic [15:0] fixed_data;
	logic        chk_err;
	logic [15:0] pass_key_q;
	logic [15:0] pass_key_d;
	logic [23:0] gpr_addr;

	// word registers span 2 bytes; byte registers pair as low/high
	always_comb begin
		if (word) begin
			gpr_addr = {8'h00, bank_base_pointer + {11'h000, gpr_idx, 1'b0}};
		end else begin
			gpr_addr = {8'h00, bank_base_pointer + {12'h000, gpr_idx[2:0], gpr_idx[3]}};
		end
	end

	assign ea = gpr_op ? gpr_addr : addr;

	// address decode across the full 24-bit space
	always_comb begin
		if (ea[23:16] == 8'h00) begin
			if (ea <= memory_space_decoder_pkg::EXT0_END) begin
				tgt_c = memory_space_decoder_pkg::TGT_EXT;
			end else if (ea <= memory_space_decoder_pkg::DRAM_RSV_HI) begin
				tgt_c = memory_space_decoder_pkg::TGT_TRAP;
			end else if (ea <= memory_space_decoder_pkg::DRAM_HI) begin
				tgt_c = memory_space_decoder_pkg::TGT_DATA_RAM;
			end else if (ea <= memory_space_decoder_pkg::XFR_HI) begin
				tgt_c = memory_space_decoder_pkg::TGT_XFR;
			end else if (ea <= memory_space_decoder_pkg::EFR_HI) begin
				tgt_c = memory_space_decoder_pkg::TGT_EFR;
			end else if (ea <= memory_space_decoder_pkg::DPR_RSV_HI) begin
				tgt_c = memory_space_decoder_pkg::TGT_TRAP;
			end else if (ea <= memory_space_decoder_pkg::DPR_HI) begin
				tgt_c = memory_space_decoder_pkg::TGT_DUAL_PORT_RAM;
			end else begin
				tgt_c = memory_space_decoder_pkg::TGT_FR;
			end
		end else if (ea >= memory_space_decoder_pkg::EXTIO_LO &&
			ea <= memory_space_decoder_pkg::EXTIO_HI) begin
			tgt_c = memory_space_decoder_pkg::TGT_EXTIO;
		end else if (ea >= memory_space_decoder_pkg::FLASH_LO &&
			ea <= memory_space_decoder_pkg::FLASH_HI) begin
			tgt_c = memory_space_decoder_pkg::TGT_FLASH;
		end else if (ea >= memory_space_decoder_pkg::PRAM_LO &&
			ea <= memory_space_decoder_pkg::PRAM_HI) begin
			tgt_c = memory_space_decoder_pkg::TGT_PRAM;
		end else if (ea < memory_space_decoder_pkg::FLASH_LO) begin
			tgt_c = memory_space_decoder_pkg::TGT_EXT;
		end else begin
			tgt_c = memory_space_decoder_pkg::TGT_TRAP;
		end
		if (tgt_c == memory_space_decoder_pkg::TGT_TRAP && ext_bus_present) begin
			tgt_c = memory_space_decoder_pkg::TGT_EXT;
		end
	end

	// lanes, bit addressing, protection and stack limits
	always_comb begin
		misal_c = word && ea[0];
		if (word) begin
			be_c = 2'h3;
		end else begin
			be_c = ea[0] ? 2'h2 : 2'h1;
		end
		bit_ok_c = (tgt_c == memory_space_decoder_pkg::TGT_DUAL_PORT_RAM &&
			ea >= memory_space_decoder_pkg::DPR_BIT_LO) ||
			(gpr_op && tgt_c == memory_space_decoder_pkg::TGT_DUAL_PORT_RAM) ||
			tgt_c == memory_space_decoder_pkg::TGT_FR ||
			tgt_c == memory_space_decoder_pkg::TGT_EFR;
		// control sector never written by the cpu; with flash_rprot set, every flash read needs the unlock
		wp_c = write && tgt_c == memory_space_decoder_pkg::TGT_FLASH &&
			((ea >= memory_space_decoder_pkg::FLASH_CTL_LO &&
			ea <= memory_space_decoder_pkg::FLASH_CTL_HI) ||
			sector_wprot[ea[15:12]]);
		rp_c = !write && tgt_c == memory_space_decoder_pkg::TGT_FLASH &&
			flash_rprot && unlk_q != memory_space_decoder_pkg::UNLK_OPEN;
		block_c = wp_c || rp_c || (bit_op && !bit_ok_c) ||
			(write && pram_prot_en &&
			tgt_c == memory_space_decoder_pkg::TGT_PRAM &&
			ea[14:0] < pram_prot_size);
		ovf_c = stack_op && ea[15:0] < stack_overflow_limit;
		unf_c = stack_op && ea[15:0] > stack_underflow_limit;
	end

	parity_secded u_check (
		.data_in   (tgt_rdata),
		.check_in  (tgt_check),
		.parity_in (tgt_parity),
		.parity_en (parity_en),
		.ecc_en    (ecc_en),
		.data_out  (fixed_data),
		.error     (chk_err)
	);

	// request/answer sequencing; one access in flight
	always_comb begin
		busy_d = busy_q;
		tgt_d = tgt_q;
		ext_d = ext_q;
		req_d = 1'b0;
		sel_d = sel_q;
		taddr_d = taddr_q;
		be_d = be_q;
		wr_d = wr_q;
		wd_d = wd_q;
		bok_d = bok_q;
		ack_d = 1'b0;
		rd_d = rd_q;
		perr_d = 1'b0;
		aerr_d = 1'b0;
		perr2_d = 1'b0;
		ovf_d = ovf_q;
		unf_d = unf_q;
		strict_d = strict_q;
		byte_hi_d = byte_hi_q;
		word_d = word_q;
		if (!busy_q && req) begin
			ovf_d = ovf_c;
			unf_d = unf_c;
			bok_d = bit_ok_c;
			if (misal_c || block_c) begin
				ack_d = 1'b1;
				aerr_d = misal_c;
				perr2_d = block_c;
				rd_d = '0;
			end else begin
				busy_d = 1'b1;
				req_d = 1'b1;
				tgt_d = tgt_c;
				sel_d = tgt_c;
				taddr_d = ea;
				be_d = be_c;
				wr_d = write;
				// byte writes replicate the byte on both lanes
				wd_d = word ? wdata : {wdata[7:0], wdata[7:0]};
				byte_hi_d = ea[0];
				word_d = word;
				ext_d = tgt_c == memory_space_decoder_pkg::TGT_EXTIO;
				strict_d = tgt_c == memory_space_decoder_pkg::TGT_EXTIO;
			end
		end else if (busy_q && tgt_done) begin
			busy_d = 1'b0;
			ack_d = 1'b1;
			strict_d = 1'b0;
			perr_d = chk_err && !wr_q;
			if (chk_err || wr_q) begin
				rd_d = '0;
			end else if (word_q) begin
				rd_d = fixed_data;
			end else begin
				rd_d = {8'h00, byte_hi_q ? fixed_data[15:8] : fixed_data[7:0]};
			end
		end
	end

	// password: two strobes, any first value then its complement
	always_comb begin
		unlk_d = unlk_q;
		pass_key_d = pass_key_q;
		if (pw_relock) begin
			unlk_d = memory_space_decoder_pkg::UNLK_LOCKED;
		end else begin
			case (unlk_q)
				memory_space_decoder_pkg::UNLK_LOCKED: begin
					if (pw_strobe) begin
						pass_key_d = password;
						unlk_d = memory_space_decoder_pkg::UNLK_FIRST;
					end
				end
				memory_space_decoder_pkg::UNLK_FIRST: begin
					if (pw_strobe) begin
						unlk_d = (password == ~pass_key_q) ?
							memory_space_decoder_pkg::UNLK_OPEN :
							memory_space_decoder_pkg::UNLK_LOCKED;
					end
				end
				default: begin
					unlk_d = unlk_q;
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			busy_q <= 1'b0;
			tgt_q <= memory_space_decoder_pkg::TGT_NONE;
			ext_q <= 1'b0;
			req_q <= 1'b0;
			sel_q <= 4'h0;
			taddr_q <= 24'h000000;
			be_q <= 2'h0;
			wr_q <= 1'b0;
			wd_q <= 16'h0000;
			bok_q <= 1'b0;
			ack_q <= 1'b0;
			rd_q <= 16'h0000;
			perr_q <= 1'b0;
			aerr_q <= 1'b0;
			perr2_q <= 1'b0;
			ovf_q <= 1'b0;
			unf_q <= 1'b0;
			strict_q <= 1'b0;
			byte_hi_q <= 1'b0;
			word_q <= 1'b0;
			unlk_q <= memory_space_decoder_pkg::UNLK_LOCKED;
			pass_key_q <= memory_space_decoder_pkg::PASSWORD_RST;
		end else begin
			busy_q <= busy_d;
			tgt_q <= tgt_d;
			ext_q <= ext_d;
			req_q <= req_d;
			sel_q <= sel_d;
			taddr_q <= taddr_d;
			be_q <= be_d;
			wr_q <= wr_d;
			wd_q <= wd_d;
			bok_q <= bok_d;
			ack_q <= ack_d;
			rd_q <= rd_d;
			perr_q <= perr_d;
			aerr_q <= aerr_d;
			perr2_q <= perr2_d;
			ovf_q <= ovf_d;
			unf_q <= unf_d;
			strict_q <= strict_d;
			byte_hi_q <= byte_hi_d;
			word_q <= word_d;
			unlk_q <= unlk_d;
			pass_key_q <= pass_key_d;
		end
	end

	assign tgt_req = req_q;
	assign tgt_sel = sel_q;
	assign tgt_addr = taddr_q;
	assign tgt_be = be_q;
	assign tgt_write = wr_q;
	assign tgt_wdata = wd_q;
	assign tgt_bit_ok = bok_q;
	assign tgt_segment = taddr_q[23:16];
	assign tgt_page = taddr_q[15:14];
	// 128-byte program blocks: 32 per 4K sector, upper bits stay zero
	assign tgt_flash_block = {2'b00, taddr_q[11:7]};
	assign ack = ack_q;
	assign rdata = rd_q;
	assign err_parity = perr_q;
	assign err_align = aerr_q;
	assign err_prot = perr2_q;
	assign stack_overflow = ovf_q;
	assign stack_underflow = unf_q;
	assign strict_order = strict_q;
	assign flash_unlocked = unlk_q == memory_space_decoder_pkg::UNLK_OPEN;

	property p_misalign_ack;
		@(posedge mclk) disable iff (!rst_n)
		(!busy_q && req && word && ea[0]) |=> (ack && err_align && !tgt_req);
	endproperty
	a_misalign_ack: assert property (p_misalign_ack) else $error("odd word not refused");

	property p_dram_decode;
		@(posedge mclk) disable iff (!rst_n)
		(!busy_q && req && !misal_c && !block_c && ea >= 24'h00a000 &&
		ea <= 24'h00dfff) |=> (tgt_req && tgt_sel == 4'h2);
	endproperty
	a_dram_decode: assert property (p_dram_decode) else $error("data ram decode");

	property p_reserved_ext;
		@(posedge mclk) disable iff (!rst_n)
		(!busy_q && req && !block_c && !misal_c && ext_bus_present &&
		ea >= 24'h008000 && ea <= 24'h009fff) |=> (tgt_sel == 4'h1);
	endproperty
	a_reserved_ext: assert property (p_reserved_ext) else $error("reserved not external");

	property p_flash_rprot;
		@(posedge mclk) disable iff (!rst_n)
		(!busy_q && req && !write && flash_rprot && !flash_unlocked &&
		tgt_c == memory_space_decoder_pkg::TGT_FLASH) |=> (ack && err_prot);
	endproperty
	a_flash_rprot: assert property (p_flash_rprot) else $error("flash read leaked");

	property p_pram_wprot;
		@(posedge mclk) disable iff (!rst_n)
		(!busy_q && req && write && pram_prot_en && !misal_c &&
		tgt_c == memory_space_decoder_pkg::TGT_PRAM &&
		ea[14:0] < pram_prot_size) |=> (err_prot && !tgt_req);
	endproperty
	a_pram_wprot: assert property (p_pram_wprot) else $error("pram write passed");

	property p_parity_hide;
		@(posedge mclk) disable iff (!rst_n)
		(busy_q && tgt_done && chk_err && !wr_q) |=> (err_parity && rdata == 16'h0000);
	endproperty
	a_parity_hide: assert property (p_parity_hide) else $error("bad data delivered");

	property p_stack_limits;
		@(posedge mclk) disable iff (!rst_n)
		(!busy_q && req && stack_op) |=>
		(stack_overflow == $past(ea[15:0] < stack_overflow_limit) &&
		stack_underflow == $past(ea[15:0] > stack_underflow_limit));
	endproperty
	a_stack_limits: assert property (p_stack_limits) else $error("stack check");

	property p_byte_lane;
		@(posedge mclk) disable iff (!rst_n)
		(!busy_q && req && !word && !block_c) |=> (tgt_be == ($past(ea[0]) ? 2'h2 : 2'h1));
	endproperty
	a_byte_lane: assert property (p_byte_lane) else $error("byte lane");

	property p_strict_io;
		@(posedge mclk) disable iff (!rst_n)
		(tgt_req && tgt_sel == 4'h9) |-> strict_order;
	endproperty
	a_strict_io: assert property (p_strict_io) else $error("io not ordered");
endmodule : memory_space_decoder

// ===== rtl/memory_space_decoder_pkg.sv
// memory_space_decoder_pkg: address map, region codes and field layout
// assumes 24-bit byte addresses from the cpu core
package memory_space_decoder_pkg;
	localparam int ADDR_W = 24;
	localparam int DATA_W = 16;
	localparam int SEG_W = 8;
	localparam int PAGE_LSB = 14;
	localparam int SEG_LSB = 16;
	localparam logic [23:0] EXT0_END = 24'h007fff;
	localparam logic [23:0] DRAM_RSV_LO = 24'h008000;
	localparam logic [23:0] DRAM_RSV_HI = 24'h009fff;
	localparam logic [23:0] DRAM_LO = 24'h00a000;
	localparam logic [23:0] DRAM_HI = 24'h00dfff;
	localparam logic [23:0] XFR_LO = 24'h00e000;
	localparam logic [23:0] XFR_HI = 24'h00efff;
	localparam logic [23:0] EFR_LO = 24'h00f000;
	localparam logic [23:0] EFR_HI = 24'h00f1ff;
	localparam logic [23:0] DPR_RSV_LO = 24'h00f200;
	localparam logic [23:0] DPR_RSV_HI = 24'h00f5ff;
	localparam logic [23:0] DPR_LO = 24'h00f600;
	localparam logic [23:0] DPR_HI = 24'h00fdff;
	localparam logic [23:0] DPR_BIT_LO = 24'h00fd00;
	localparam logic [23:0] FR_LO = 24'h00fe00;
	localparam logic [23:0] FR_HI = 24'h00ffff;
	localparam logic [23:0] EXTIO_LO = 24'h200000;
	localparam logic [23:0] EXTIO_HI = 24'h3fffff;
	localparam logic [23:0] FLASH_LO = 24'hc00000;
	localparam logic [23:0] FLASH_HI = 24'hccffff;
	localparam logic [23:0] FLASH_CTL_LO = 24'hc0f000;
	localparam logic [23:0] FLASH_CTL_HI = 24'hc0ffff;
	localparam logic [23:0] PRAM_LO = 24'he00000;
	localparam logic [23:0] PRAM_HI = 24'he07fff;
	localparam int SECTOR_LSB = 12;
	localparam int BLOCK_LSB = 7;
	localparam int SECTOR_W = 8;
	localparam int GPR_IDX_W = 4;
	localparam int STACK_MAX_WORDS = 32768;
	localparam logic [15:0] PASSWORD_RST = 16'h0000;
	localparam logic [5:0] ECC_SYND_W = 6'h05;

	typedef enum logic [3:0] {
		TGT_NONE      = 4'h0,
		TGT_EXT       = 4'h1,
		TGT_DATA_RAM  = 4'h2,
		TGT_XFR       = 4'h3,
		TGT_EFR       = 4'h4,
		TGT_DUAL_PORT_RAM     = 4'h5,
		TGT_FR        = 4'h6,
		TGT_FLASH     = 4'h7,
		TGT_PRAM      = 4'h8,
		TGT_EXTIO     = 4'h9,
		TGT_TRAP      = 4'ha
	} target_t;

	typedef enum logic [1:0] {
		UNLK_LOCKED = 2'h0,
		UNLK_FIRST  = 2'h1,
		UNLK_OPEN   = 2'h2
	} unlock_t;
endpackage : memory_space_decoder_pkg

// ===== rtl/parity_secded.sv
// parity_secded: single-error-correcting check on a 16-bit word
// assumes check bits were written by the same code on the memory side
`timescale 1ns/1ps
module parity_secded (
	// stored word and check bits
	input  wire logic [15:0] data_in,
	input  wire logic [4:0]  check_in,
	input  wire logic        parity_in,
	// controls
	input  wire logic        parity_en,
	input  wire logic        ecc_en,
	// result
	output logic [15:0]      data_out,
	output logic             error
);
	logic [20:0] cw;
	logic [4:0]  synd;
	logic        par;
	logic [20:0] fixed;
	int          i;
	int          k;

	// hamming positions 1..21 skipping powers of two for data bits
	always_comb begin
		cw = '0;
		k = 0;
		for (i = 1; i <= 21; i++) begin
			if ((i & (i - 1)) != 0) begin
				cw[i-1] = data_in[k];
				k = k + 1;
			end
		end
		cw[0] = check_in[0];
		cw[1] = check_in[1];
		cw[3] = check_in[2];
		cw[7] = check_in[3];
		cw[15] = check_in[4];
		synd = '0;
		for (i = 1; i <= 21; i++) begin
			if (cw[i-1]) begin
				synd = synd ^ i[4:0];
			end
		end
		fixed = cw;
		if (ecc_en && synd != 5'h00 && synd <= 5'd21) begin
			fixed[synd-5'd1] = ~cw[synd-5'd1];
		end
		data_out = '0;
		k = 0;
		for (i = 1; i <= 21; i++) begin
			if ((i & (i - 1)) != 0) begin
				data_out[k] = fixed[i-1];
				k = k + 1;
			end
		end
		par = ^{data_in, parity_in};
		// parity only flags; with ecc_en set, ecc repairs one bit and error stays low whatever the syndrome
		error = parity_en && !ecc_en && par;
	end
endmodule : parity_secded

// ===== sim/target_model.sv
// target_model: memory side of the decoder, answers every tgt_req
// assumes tgt_req pulses once per access and waits for tgt_done
`timescale 1ns/1ps
module target_model (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_n,
	// decoder side
	input  wire logic        tgt_req,
	input  wire logic [23:0] tgt_addr,
	input  wire logic [1:0]  tgt_be,
	input  wire logic        tgt_write,
	input  wire logic [15:0] tgt_wdata,
	output logic [15:0]      tgt_rdata,
	output logic [4:0]       tgt_check,
	output logic             tgt_parity,
	output logic             tgt_done,
	// scenario controls
	input  wire logic [3:0]  lat,
	input  wire logic        flip
);
	logic [15:0] mem [logic [22:0]];
	logic [15:0] word_q;
	logic [15:0] cur;
	logic        busy_q;
	int          wait_q;

	// check bits make the hamming syndrome of the stored word zero
	function automatic logic [4:0] hchk(input logic [15:0] d);
		int         k;
		logic [4:0] s;
		k = 0;
		s = '0;
		for (int i = 3; i <= 21; i++) begin
			if ((i & (i - 1)) != 0) begin
				if (d[k]) s = s ^ i[4:0];
				k++;
			end
		end
		return s;
	endfunction : hchk

	initial begin
		busy_q = 1'b0;
		tgt_done = 1'b0;
		tgt_rdata = 16'h0000;
		tgt_check = 5'h00;
		tgt_parity = 1'b0;
	end

	always @(posedge mclk) begin
		tgt_done <= 1'b0;
		// an idle bus alternates the last word with its complement each cycle
		tgt_rdata <= ~tgt_rdata;
		if (!rst_n) begin
			busy_q <= 1'b0;
		end else if (busy_q && wait_q == 0) begin
			busy_q <= 1'b0;
			tgt_done <= 1'b1;
			// corruption lands after parity was stored
			tgt_rdata <= word_q ^ {15'h0000, flip};
			tgt_parity <= ^word_q;
			tgt_check <= hchk(word_q);
		end else if (busy_q) begin
			wait_q <= wait_q - 1;
		end else if (tgt_req) begin
			cur = mem.exists(tgt_addr[23:1]) ? mem[tgt_addr[23:1]]
				: {tgt_addr[7:0], ~tgt_addr[7:0]};
			if (tgt_write && tgt_be[0]) cur[7:0] = tgt_wdata[7:0];
			if (tgt_write && tgt_be[1]) cur[15:8] = tgt_wdata[15:8];
			if (tgt_write) mem[tgt_addr[23:1]] = cur;
			word_q <= cur;
			wait_q <= lat;
			busy_q <= 1'b1;
		end
	end
endmodule : target_model

// ===== sim/tb_top.sv
// tb_top: self-checking bench for memory_space_decoder
// assumes each access is answered within forty cycles
`timescale 1ns/1ps
module tb_top;
	logic        mclk, rst_n, req, fetch, write, word, bit_op, gpr_op;
	logic        stack_op, ext_bus_present, flash_rprot, pw_strobe;
	logic        pw_relock, pram_prot_en, parity_en, ecc_en, flip;
	logic [3:0]  gpr_idx, lat, tgt_sel;
	logic [23:0] addr, tgt_addr;
	logic [15:0] wdata, bank_base_pointer, stack_overflow_limit;
	logic [15:0] stack_underflow_limit, sector_wprot, password;
	logic [14:0] pram_prot_size;
	logic [15:0] tgt_rdata, tgt_wdata, rdata, got_rd;
	logic [4:0]  tgt_check;
	logic [1:0]  tgt_be, tgt_page;
	logic [7:0]  tgt_segment;
	logic [6:0]  tgt_flash_block;
	logic        tgt_parity, tgt_done, tgt_req, tgt_write, tgt_bit_ok;
	logic        ack, err_parity, err_align, err_prot, stack_overflow;
	logic        stack_underflow, strict_order, flash_unlocked, saw, so;
	logic [2:0]  got_err;
	int          fail_count = 0;
	int          cmp_count = 0;

	memory_space_decoder u_dut (.mclk, .rst_n, .req, .fetch, .write, .word,
		.bit_op, .gpr_op, .gpr_idx, .stack_op, .addr, .wdata,
		.ext_bus_present, .bank_base_pointer, .stack_overflow_limit,
		.stack_underflow_limit, .sector_wprot, .flash_rprot, .password,
		.pw_strobe, .pw_relock, .pram_prot_size, .pram_prot_en, .parity_en,
		.ecc_en, .tgt_rdata, .tgt_check, .tgt_parity, .tgt_done, .tgt_req,
		.tgt_sel, .tgt_addr, .tgt_be, .tgt_write, .tgt_wdata, .tgt_bit_ok,
		.tgt_segment, .tgt_page, .tgt_flash_block, .ack, .rdata,
		.err_parity, .err_align, .err_prot, .stack_overflow,
		.stack_underflow, .strict_order, .flash_unlocked);
	target_model u_mem (.mclk, .rst_n, .tgt_req, .tgt_addr, .tgt_be,
		.tgt_write, .tgt_wdata, .tgt_rdata, .tgt_check, .tgt_parity,
		.tgt_done, .lat, .flip);

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	task automatic chk(input string nm, input logic [23:0] e,
			input logic [23:0] g);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// f = {bit_op, gpr_op, stack_op, fetch}; ends at the ack cycle
	task automatic access(input logic [23:0] a, input logic w,
			input logic wd, input logic [15:0] d, input logic [3:0] f);
		int n;
		@(negedge mclk);
		addr = a;
		write = w;
		word = wd;
		wdata = d;
		{bit_op, gpr_op, stack_op, fetch} = f;
		req = 1'b1;
		@(negedge mclk);
		req = 1'b0;
		{saw, so, got_err} = '0;
		for (n = 0; n < 40 && ack !== 1'b1; n++) begin
			saw |= (tgt_req === 1'b1);
			so |= (strict_order === 1'b1);
			@(negedge mclk);
		end
		so |= (strict_order === 1'b1);
		got_rd = rdata;
		got_err = {err_parity, err_align, err_prot};
		if (ack !== 1'b1) chk("ack", 1, 0);
	endtask : access

	task automatic t_decode();
		logic [23:0] a [12] = '{24'h007ffe, 24'h008000, 24'h00a000,
			24'h00dffe, 24'h00e000, 24'h00f000, 24'h00f600, 24'h00fe00,
			24'h210000, 24'hc00000, 24'he00000, 24'h01a000};
		logic [3:0] s [12] = '{4'h1, 4'h1, 4'h2, 4'h2, 4'h3, 4'h4, 4'h5,
			4'h6, 4'h9, 4'h7, 4'h8, 4'h1};
		for (int i = 0; i < 12; i++) begin
			access(a[i], 1'b0, 1'b1, 16'h0000, 4'h0);
			chk("tgt_sel", s[i], tgt_sel);
			chk("tgt_segment", a[i][23:16], tgt_segment);
			chk("tgt_page", a[i][15:14], tgt_page);
			chk("strict_order", s[i] == 4'h9, so);
		end
		ext_bus_present = 1'b0;
		access(24'h009000, 1'b0, 1'b1, 16'h0000, 4'h0);
		chk("tgt_sel", 4'ha, tgt_sel);
		ext_bus_present = 1'b1;
	endtask : t_decode

	task automatic t_bytes();
		lat = 4'h3;
		access(24'h00a010, 1'b1, 1'b1, 16'h1234, 4'h0);
		chk("tgt_be", 2'h3, tgt_be);
		chk("tgt_write", 1, tgt_write);
		access(24'h00a011, 1'b1, 1'b0, 16'h00ab, 4'h0);
		chk("tgt_be", 2'h2, tgt_be);
		chk("tgt_wdata", 16'habab, tgt_wdata);
		access(24'h00a010, 1'b0, 1'b1, 16'h0000, 4'h0);
		chk("rdata", 16'hab34, got_rd);
		access(24'h00a011, 1'b0, 1'b0, 16'h0000, 4'h0);
		chk("rdata", 8'hab, got_rd[7:0]);
		access(24'h00a011, 1'b0, 1'b1, 16'h0000, 4'h0);
		chk("err", 3'h2, got_err);
		chk("tgt_req", 0, saw);
		lat = 4'h0;
	endtask : t_bytes

	task automatic t_bank();
		access(24'h00fd00, 1'b0, 1'b1, 16'h0000, 4'h8);
		chk("tgt_bit_ok", 1, tgt_bit_ok);
		access(24'h00fcfe, 1'b0, 1'b1, 16'h0000, 4'h8);
		chk("err", 3'h1, got_err);
		chk("tgt_req", 0, saw);
		bank_base_pointer = 16'hf600;
		gpr_idx = 4'h2;
		access(24'h000000, 1'b0, 1'b1, 16'h0000, 4'hc);
		chk("tgt_addr", 24'h00f604, tgt_addr);
		chk("tgt_bit_ok", 1, tgt_bit_ok);
		bank_base_pointer = 16'hf700;
		gpr_idx = 4'hf;
		access(24'h000000, 1'b0, 1'b1, 16'h0000, 4'h4);
		chk("tgt_addr", 24'h00f71e, tgt_addr);
		gpr_idx = 4'hb;
		access(24'h000000, 1'b0, 1'b0, 16'h0000, 4'h4);
		chk("tgt_addr", 24'h00f707, tgt_addr);
		chk("tgt_be", 2'h2, tgt_be);
		bank_base_pointer = 16'hf702;
		gpr_idx = 4'h0;
		access(24'h000000, 1'b0, 1'b1, 16'h0000, 4'h4);
		chk("tgt_addr", 24'h00f702, tgt_addr);
	endtask : t_bank

	task automatic t_stack();
		logic [23:0] a [4] = '{24'h00f900, 24'h00fd00, 24'h00fa00,
			24'h00fc00};
		stack_overflow_limit = 16'hfa00;
		stack_underflow_limit = 16'hfc00;
		for (int i = 0; i < 4; i++) begin
			access(a[i], 1'b1, 1'b1, 16'h5555, 4'h2);
			chk("stack_overflow", i == 0, stack_overflow);
			chk("stack_underflow", i == 1, stack_underflow);
		end
	endtask : t_stack

	task automatic pw(input logic [15:0] k);
		@(negedge mclk);
		password = k;
		pw_strobe = 1'b1;
		@(negedge mclk);
		pw_strobe = 1'b0;
	endtask : pw

	task automatic t_flash();
		sector_wprot = 16'h0008;
		access(24'hc0f000, 1'b1, 1'b1, 16'h0000, 4'h0);
		chk("err", 3'h1, got_err);
		chk("tgt_req", 0, saw);
		access(24'hc13000, 1'b1, 1'b1, 16'h0000, 4'h0);
		chk("err", 3'h1, got_err);
		access(24'hc14000, 1'b1, 1'b1, 16'h0000, 4'h0);
		chk("err", 3'h0, got_err);
		flash_rprot = 1'b1;
		access(24'hc14000, 1'b0, 1'b1, 16'h0000, 4'h1);
		chk("err", 3'h1, got_err);
		pw(memory_space_decoder_pkg::PASSWORD_RST);
		pw(~memory_space_decoder_pkg::PASSWORD_RST);
		@(negedge mclk);
		chk("flash_unlocked", 1, flash_unlocked);
		access(24'hc14000, 1'b0, 1'b1, 16'h0000, 4'h1);
		chk("err", 3'h0, got_err);
		pw_relock = 1'b1;
		@(negedge mclk);
		pw_relock = 1'b0;
		access(24'hc14000, 1'b0, 1'b1, 16'h0000, 4'h1);
		chk("err", 3'h1, got_err);
		flash_rprot = 1'b0;
		access(24'hc14380, 1'b0, 1'b1, 16'h0000, 4'h1);
		chk("tgt_flash_block", 7'h07, tgt_flash_block);
	endtask : t_flash

	task automatic t_pram();
		pram_prot_size = 15'h0100;
		pram_prot_en = 1'b1;
		access(24'he000fe, 1'b1, 1'b1, 16'h0000, 4'h0);
		chk("err", 3'h1, got_err);
		chk("tgt_req", 0, saw);
		access(24'he00100, 1'b1, 1'b1, 16'h0000, 4'h0);
		chk("err", 3'h0, got_err);
		pram_prot_en = 1'b0;
		access(24'he000fe, 1'b1, 1'b1, 16'h0000, 4'h0);
		chk("err", 3'h0, got_err);
	endtask : t_pram

	task automatic t_parity();
		parity_en = 1'b1;
		flip = 1'b1;
		lat = 4'h5;
		access(24'h00a020, 1'b0, 1'b1, 16'h0000, 4'h0);
		chk("err", 3'h4, got_err);
		flip = 1'b0;
		access(24'h00a020, 1'b0, 1'b1, 16'h0000, 4'h0);
		chk("err", 3'h0, got_err);
		chk("rdata", 16'h20df, got_rd);
		ecc_en = 1'b1;
		flip = 1'b1;
		access(24'h00a020, 1'b0, 1'b1, 16'h0000, 4'h0);
		chk("err", 3'h0, got_err);
		chk("rdata", 16'h20df, got_rd);
		{parity_en, ecc_en, flip, lat} = '0;
	endtask : t_parity

	task automatic tally_and_finish();
		if (fail_count == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : tally_and_finish

	initial begin
		#2000000;
		fail_count++;
		tally_and_finish();
	end

	initial begin
		{rst_n, req, fetch, write, word, bit_op, gpr_op, stack_op} = '0;
		{flash_rprot, pw_strobe, pw_relock, pram_prot_en} = '0;
		{parity_en, ecc_en, flip, gpr_idx, lat, addr, wdata} = '0;
		{stack_overflow_limit, stack_underflow_limit, password} = '0;
		{bank_base_pointer, sector_wprot, pram_prot_size} = '0;
		ext_bus_present = 1'b1;
		repeat (10) @(negedge mclk);
		rst_n = 1'b1;
		chk("tgt_sel", 4'h0, tgt_sel);
		t_decode();
		t_bytes();
		t_bank();
		t_stack();
		t_flash();
		t_pram();
		t_parity();
		tally_and_finish();
	end
endmodule : tb_top
